// [hw/card_reader.sv]
// Card reader on-line state, card cycle and error latching
//
// How it works
// - Cards are 12 rows by 40 columns; one 12-bit zone word per column.
// - Start runs motor, clears each latched error whose cause has gone.
// - Started with motor at speed, reader goes on-line and takes feeds.
// - Stop stops the motor and drops the on-line state.
// - Stop during a card finishes that card before the motor stops.
// - Any stop or detected error drops the on-line state.
// - Empty hopper or full stacker flags supply error and stops reading.
// - No card at the read station after a feed flags feed error.
// - Read card not delivered to the stacker flags stacking error.
// - Card jam in the read station flags a jam fault.
// - Card failing the light/dark check flags a light/dark error.
// - Feed, stack, jam or light/dark error halts cards, off-line till start.
// - Each column: zone on 12 lines and a column strobe pulse, both in the same cycle.
// - Ready only while on-line and able to take a feed command.
// - Busy while reading a card; no feed command taken meanwhile.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module card_reader #(
    parameter int FEED_TIMEOUT_CYC  = reader_pkg::FEED_TIMEOUT_CYC,
    parameter int STACK_TIMEOUT_CYC = reader_pkg::STACK_TIMEOUT_CYC,
    parameter int COL_PERIOD_CYC    = reader_pkg::COL_PERIOD_CYC,
    parameter int COLS              = reader_pkg::COLS,
    parameter int ROWS              = reader_pkg::ROWS
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           srst,
    // Register port
    input  wire logic [reader_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [reader_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [reader_pkg::DATA_W-1:0]  reg_rdata,
    // Mechanism sensors and operator panel
    input  wire reader_pkg::sense_t             sense_pins,
    input  wire logic [ROWS-1:0]                sense_zone,
    input  wire logic                           start_btn,
    input  wire logic                           stop_btn,
    // Controller link
    input  wire logic                           feed_cmd,
    output logic      [ROWS-1:0]                zone,
    output logic                                column_strobe,
    output logic                                ready,
    output logic                                busy,
    output logic                                supply_error,
    output logic                                reader_check,
    // Drive, panel and interrupt
    output logic                                motor_on,
    output logic                                online,
    output logic                                irq
);
    localparam int SW = $bits(reader_pkg::sense_t);
    localparam int YW = SW + ROWS + 3;
    localparam int CW = $clog2(COLS);
    localparam int TW = 32;

    // Two-stage synchroniser for every sensor, panel and feed pin
    logic [YW-1:0]       sync1_r;
    logic [YW-1:0]       sync2_r;
    reader_pkg::sense_t  sn;
    logic [ROWS-1:0]     zone_in;
    logic                start_s;
    logic                stop_s;
    logic                feed_s;
    logic                start_prev_r;
    logic                stop_prev_r;
    logic                strobe_prev_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {sense_pins, sense_zone, start_btn, stop_btn, feed_cmd};
            sync2_r <= sync1_r;
        end
    end

    // Zone lines settle well before the strobe, so skew is harmless
    assign {sn, zone_in, start_s, stop_s, feed_s} = sync2_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            start_prev_r  <= 1'b0;
            stop_prev_r   <= 1'b0;
            strobe_prev_r <= 1'b0;
        end else begin
            start_prev_r  <= start_s;
            stop_prev_r   <= stop_s;
            strobe_prev_r <= sn.sense_strobe;
        end
    end

    // Register decode
    logic wr_ctrl;
    logic start_req;
    logic stop_req;
    logic col_in;

    assign wr_ctrl   = reg_wr && reg_addr == reader_pkg::OFS_CTRL;
    assign start_req = (start_s && !start_prev_r)
        || (wr_ctrl && reg_wdata[reader_pkg::CTRL_START_BIT]);
    assign stop_req  = (stop_s && !stop_prev_r)
        || (wr_ctrl && reg_wdata[reader_pkg::CTRL_STOP_BIT]);
    assign col_in    = sn.sense_strobe && !strobe_prev_r;

    // Card cycle state
    reader_pkg::state_t state_r;
    logic [TW-1:0]      tmr_r;
    logic [CW-1:0]      col_r;
    logic               rd_pend_r;
    logic               tick;
    logic [ROWS-1:0]    mem_rd;
    logic               feed_take;
    logic               last_col;

    // Latched errors
    reader_pkg::err_t   err_r;
    reader_pkg::err_t   err_set;
    reader_pkg::err_t   err_clr;
    reader_pkg::err_t   err_nxt;
    logic               halt;
    logic               stop_pend_r;
    logic               online_en_r;
    logic               online_en_nxt;
    logic               online_nxt;

    assign last_col = col_r == CW'(COLS - 1);

    assign feed_take = ready && feed_s && state_r == reader_pkg::ST_IDLE;

    assign err_set.supply    = sn.hopper_empty || sn.stacker_full;
    assign err_set.feed      = state_r == reader_pkg::ST_FEED
        && !sn.card_in_station && tmr_r == TW'(FEED_TIMEOUT_CYC - 1);
    assign err_set.stack     = state_r == reader_pkg::ST_STACK
        && !sn.card_stacked && tmr_r == TW'(STACK_TIMEOUT_CYC - 1);
    assign err_set.jam_fault = sn.jam_sense
        && state_r != reader_pkg::ST_IDLE;
    assign err_set.ld        = sn.ld_fail && state_r == reader_pkg::ST_READ;

    assign err_clr.supply    = start_req && !err_set.supply;
    assign err_clr.feed      = start_req;
    assign err_clr.stack     = start_req;
    assign err_clr.jam_fault = start_req && !sn.jam_sense;
    assign err_clr.ld        = start_req && !sn.ld_fail;

    // levels held; a new set beats a clear
    assign err_nxt = err_set | (err_r & ~err_clr);

    // any new error halts the card
    assign halt = |err_set;

    always_ff @(posedge clk) begin
        if (srst) begin
            err_r <= '0;
        end else begin
            err_r <= err_nxt;
        end
    end

    // stop wins over a start in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            stop_pend_r <= 1'b0;
        end else if (stop_req) begin
            stop_pend_r <= 1'b1;
        end else if (start_req || !motor_on) begin
            stop_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            motor_on <= 1'b0;
        end else if (stop_pend_r && state_r == reader_pkg::ST_IDLE) begin
            motor_on <= 1'b0;
        end else if (start_req && !stop_req) begin
            motor_on <= 1'b1;
        end
    end

    assign online_en_nxt = (stop_req || halt) ? 1'b0
        : (start_req ? 1'b1 : online_en_r);
    // on-line needs start, speed, clean errors
    assign online_nxt = online_en_nxt && motor_on && sn.motor_at_speed
        && !(|err_nxt) && !stop_pend_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            online_en_r <= 1'b0;
            online      <= 1'b0;
        end else begin
            online_en_r <= online_en_nxt;
            online      <= online_nxt;
        end
    end

    // busy for the whole card cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            ready <= 1'b0;
            busy  <= 1'b0;
        end else begin
            ready <= online_nxt && state_r == reader_pkg::ST_IDLE
                && !feed_take;
            busy  <= (feed_take && !halt)
                || (state_r != reader_pkg::ST_IDLE && !halt
                    && !(state_r == reader_pkg::ST_STACK
                         && sn.card_stacked));
        end
    end

    tick_div #(
        .PERIOD (COL_PERIOD_CYC)
    ) tick_div_inst (
        .clk    (clk),
        .srst   (srst),
        .en     (state_r == reader_pkg::ST_SEND && !rd_pend_r),
        .tick   (tick)
    );

    col_mem #(
        .WIDTH   (ROWS),
        .DEPTH   (COLS)
    ) col_mem_inst (
        .clk     (clk),
        .wr_en   (state_r == reader_pkg::ST_READ && col_in),
        .wr_addr (col_r),
        .wr_data (zone_in),
        .rd_en   (tick),
        .rd_addr (col_r),
        .rd_data (mem_rd)
    );

    // Card cycle sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r   <= reader_pkg::ST_IDLE;
            tmr_r     <= '0;
            col_r     <= '0;
            rd_pend_r <= 1'b0;
        end else if (halt) begin
            state_r   <= reader_pkg::ST_IDLE;
            tmr_r     <= '0;
            col_r     <= '0;
            rd_pend_r <= 1'b0;
        end else begin
            tmr_r <= tmr_r + 1'b1;
            case (state_r)
                reader_pkg::ST_IDLE: begin
                    tmr_r <= '0;
                    if (feed_take) begin
                        state_r <= reader_pkg::ST_FEED;
                    end
                end
                reader_pkg::ST_FEED: begin
                    if (sn.card_in_station) begin
                        state_r <= reader_pkg::ST_READ;
                        col_r   <= '0;
                    end
                end
                reader_pkg::ST_READ: begin
                    if (col_in) begin
                        col_r <= last_col ? '0 : col_r + 1'b1;
                        if (last_col) begin
                            state_r <= reader_pkg::ST_SEND;
                        end
                    end
                end
                reader_pkg::ST_SEND: begin
                    tmr_r <= '0;
                    if (tick) begin
                        rd_pend_r <= 1'b1;
                    end else if (rd_pend_r) begin
                        rd_pend_r <= 1'b0;
                        col_r     <= last_col ? '0 : col_r + 1'b1;
                        if (last_col) begin
                            state_r <= reader_pkg::ST_STACK;
                        end
                    end
                end
                reader_pkg::ST_STACK: begin
                    if (sn.card_stacked) begin
                        state_r <= reader_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= reader_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            zone          <= '0;
            column_strobe <= 1'b0;
        end else begin
            column_strobe <= state_r == reader_pkg::ST_SEND && rd_pend_r
                && !halt;
            if (state_r == reader_pkg::ST_SEND && rd_pend_r) begin
                zone <= mem_rd;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            supply_error <= 1'b0;
            reader_check <= 1'b0;
        end else begin
            supply_error <= err_nxt.supply;
            reader_check <= err_nxt.feed || err_nxt.stack
                || err_nxt.jam_fault || err_nxt.ld;
        end
    end

    // Interrupt status, write one to clear, set wins
    logic [reader_pkg::IRQ_W-1:0] irq_st_r;
    logic [reader_pkg::IRQ_W-1:0] irq_mask_r;
    logic [reader_pkg::IRQ_W-1:0] irq_ev;
    logic [reader_pkg::IRQ_W-1:0] irq_w1c;
    logic [reader_pkg::IRQ_W-1:0] irq_st_nxt;

    always_comb begin
        irq_ev = '0;
        irq_ev[reader_pkg::IRQ_DONE_BIT]   = state_r == reader_pkg::ST_STACK
            && sn.card_stacked && !halt;
        irq_ev[reader_pkg::IRQ_ERR_BIT]    = |(err_set & ~err_r);
        irq_ev[reader_pkg::IRQ_ONLINE_BIT] = online_nxt && !online;
    end

    assign irq_w1c = (reg_wr && reg_addr == reader_pkg::OFS_IRQ_STAT)
        ? reg_wdata[reader_pkg::IRQ_W-1:0] : '0;
    assign irq_st_nxt = irq_ev | (irq_st_r & ~irq_w1c);

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_st_r   <= reader_pkg::IRQ_STAT_RST;
            irq_mask_r <= reader_pkg::IRQ_MASK_RST;
            irq        <= 1'b0;
        end else begin
            irq_st_r <= irq_st_nxt;
            if (reg_wr && reg_addr == reader_pkg::OFS_IRQ_MASK) begin
                irq_mask_r <= reg_wdata[reader_pkg::IRQ_W-1:0];
                irq        <= |(irq_st_nxt
                    & reg_wdata[reader_pkg::IRQ_W-1:0]);
            end else begin
                irq <= |(irq_st_nxt & irq_mask_r);
            end
        end
    end

    // Register reads, one cycle later; unmapped reads give zero
    reader_pkg::status_t stat;

    always_comb begin
        stat.online    = online;
        stat.ready     = ready;
        stat.busy      = busy;
        stat.motor     = motor_on;
        stat.stop_pend = stop_pend_r;
        stat.err       = err_r;
        stat.state     = state_r;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                reader_pkg::OFS_STATUS:
                    reg_rdata <= reader_pkg::DATA_W'(stat);
                reader_pkg::OFS_IRQ_STAT:
                    reg_rdata <= reader_pkg::DATA_W'(irq_st_r);
                reader_pkg::OFS_IRQ_MASK:
                    reg_rdata <= reader_pkg::DATA_W'(irq_mask_r);
                reader_pkg::OFS_COLUMN:
                    reg_rdata <= reader_pkg::DATA_W'(zone);
                default:
                    reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule

// [inc/reader_pkg.sv]
// Shared constants and types for the card reader on-line and error logic
package reader_pkg;

    // Clock and card geometry
    localparam int CLK_MHZ           = 100;
    localparam int COLS              = 40;
    localparam int ROWS              = 12;

    // Timing, as figures in their own units
    localparam int FEED_TIMEOUT_US   = 1000;
    localparam int STACK_TIMEOUT_US  = 2000;
    localparam int COL_PERIOD_NS     = 2000;

    // Timing in clock cycles (column period rounds down)
    localparam int FEED_TIMEOUT_CYC  = FEED_TIMEOUT_US * CLK_MHZ;
    localparam int STACK_TIMEOUT_CYC = STACK_TIMEOUT_US * CLK_MHZ;
    localparam int COL_PERIOD_CYC    = (COL_PERIOD_NS * CLK_MHZ) / 1000;

    // Register port
    localparam int ADDR_W            = 8;
    localparam int DATA_W            = 16;
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h0C;
    localparam logic [7:0] OFS_COLUMN    = 8'h10;

    // Control register fields (write-only pulses)
    localparam int CTRL_START_BIT    = 0;
    localparam int CTRL_STOP_BIT     = 1;

    // Interrupt status and mask layout
    localparam int IRQ_W             = 3;
    localparam int IRQ_DONE_BIT      = 0;
    localparam int IRQ_ERR_BIT       = 1;
    localparam int IRQ_ONLINE_BIT    = 2;
    localparam logic [2:0] IRQ_MASK_RST  = 3'h0;
    localparam logic [2:0] IRQ_STAT_RST  = 3'h0;

    // Card handling states, Gray from idle through to stack
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FEED  = 3'h1,
        ST_READ  = 3'h3,
        ST_SEND  = 3'h2,
        ST_STACK = 3'h6
    } state_t;

    // Mechanism sensor pins
    typedef struct packed {
        logic hopper_empty;
        logic stacker_full;
        logic motor_at_speed;
        logic card_in_station;
        logic card_stacked;
        logic jam_sense;
        logic ld_fail;
        logic sense_strobe;
    } sense_t;

    // Latched error indications
    typedef struct packed {
        logic supply;
        logic feed;
        logic stack;
        logic jam_fault;
        logic ld;
    } err_t;

    // Status register layout, high bits first, state in the low bits
    typedef struct packed {
        logic   online;
        logic   ready;
        logic   busy;
        logic   motor;
        logic   stop_pend;
        err_t   err;
        state_t state;
    } status_t;

endpackage

// [hw/tick_div.sv]
// Divider giving a one-cycle enable pulse every PERIOD cycles while enabled
`timescale 1ns/1ns
module tick_div #(
    parameter int PERIOD = 200
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Control and pulse
    input  wire logic en,
    output logic      tick
);
    localparam int CW = $clog2(PERIOD + 1);

    logic [CW-1:0] cnt_r;

    // Restarts on every enable so the first pulse is a full period away
    always_ff @(posedge clk) begin
        if (srst || !en) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (cnt_r == CW'(PERIOD - 1)) begin
            cnt_r <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule

// [hw/col_mem.sv]
// Column store for one card, registered read data
`timescale 1ns/1ns
module col_mem #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 40
) (
    // Clock
    input  wire logic                     clk,
    // Write side
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    // Read side
    input  wire logic                     rd_en,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule

// [verif/card_reader_props.sv]
// Checker for the reader's on-line, link and error rules
`timescale 1ns/1ns
module card_reader_props (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched pins
    input wire logic stop_btn,
    input wire logic column_strobe,
    input wire logic ready,
    input wire logic busy,
    input wire logic supply_error,
    input wire logic reader_check,
    input wire logic motor_on,
    input wire logic online
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence stop_pressed;
        $rose(stop_btn);
    endsequence
    sequence offline_soon;
        ##[1:6] !online;
    endsequence

    ready_online_a: assert property (ready |-> online)
        else $error("ready while off-line");
    ready_busy_a: assert property (!(ready && busy))
        else $error("ready and busy together");
    feed_take_a: assert property ($rose(busy) |-> $past(ready))
        else $error("card taken while not ready");
    strobe_pulse_a: assert property (
        column_strobe |=> !column_strobe)
        else $error("column strobe longer than a cycle");
    strobe_busy_a: assert property (column_strobe |-> busy)
        else $error("column strobe outside a card");
    stop_offline_a: assert property (stop_pressed |-> offline_soon)
        else $error("stop left reader on-line");
    check_offline_a: assert property (
        $rose(reader_check) |-> ##[0:2] !online)
        else $error("reader check left reader on-line");
    supply_offline_a: assert property (
        $rose(supply_error) |-> ##[0:2] !online)
        else $error("supply error left reader on-line");
    online_motor_a: assert property ($rose(online) |-> motor_on)
        else $error("on-line without motor");
    motor_hold_a: assert property (busy ##1 busy |-> $past(motor_on))
        else $error("motor stopped during a card");
endmodule

bind card_reader card_reader_props card_reader_props_inst (
    .clk(clk), .srst(srst), .stop_btn(stop_btn),
    .column_strobe(column_strobe), .ready(ready), .busy(busy),
    .supply_error(supply_error), .reader_check(reader_check),
    .motor_on(motor_on), .online(online)
);

// [verif/ctl_model.sv]
// Controller-side model: drives the feed line and captures columns
`timescale 1ns/1ns
module ctl_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Request from the bench
    input  wire logic        go,
    // Reader link
    input  wire logic [11:0] zone,
    input  wire logic        column_strobe,
    input  wire logic        supply_error,
    input  wire logic        reader_check,
    output logic             feed_cmd,
    output logic      [5:0]  ncol
);
    logic [11:0] mem [0:39];
    logic [1:0]  err_seen;
    always_ff @(posedge clk) begin
        err_seen <= {supply_error, reader_check};
    end
    always_ff @(posedge clk) begin
        feed_cmd <= go && !srst;
    end
    always_ff @(posedge clk) begin
        if (srst || (go && !feed_cmd)) begin
            ncol <= 6'h00;
        end else if (column_strobe) begin
            mem[ncol] <= zone;
            ncol      <= ncol + 6'h01;
        end
    end
endmodule

// [verif/card_reader_test.sv]
// Self-checking bench for the reader on-line and error logic
`timescale 1ns/1ns
module card_reader_test;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic [7:0]         reg_addr = 8'h00;
    logic [15:0]        reg_wdata = 16'h0000;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [15:0]        reg_rdata;
    reader_pkg::sense_t sense_pins = 8'h20;
    logic [11:0]        sense_zone = 12'h000;
    logic               start_btn = 1'b0;
    logic               stop_btn = 1'b0;
    logic               go = 1'b0;
    logic               feed_cmd, column_strobe, ready, busy, irq;
    logic               supply_error, reader_check, motor_on, online;
    logic [11:0]        zone;
    logic [5:0]         ncol;
    int                 mismatches = 0;
    int                 samples_checked = 0;

    always #5 clk = ~clk;

    card_reader #(.FEED_TIMEOUT_CYC(50), .STACK_TIMEOUT_CYC(80),
        .COL_PERIOD_CYC(4)) card_reader_inst (.clk(clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sense_pins(sense_pins),
        .sense_zone(sense_zone), .start_btn(start_btn),
        .stop_btn(stop_btn), .feed_cmd(feed_cmd), .zone(zone),
        .column_strobe(column_strobe), .ready(ready), .busy(busy),
        .supply_error(supply_error), .reader_check(reader_check),
        .motor_on(motor_on), .online(online), .irq(irq));
    ctl_model ctl_model_inst (.clk(clk), .srst(srst), .go(go),
        .zone(zone), .column_strobe(column_strobe),
        .supply_error(supply_error), .reader_check(reader_check),
        .feed_cmd(feed_cmd), .ncol(ncol));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic cond(input int sel);
        case (sel)
            0: cond = (ready === 1'b1);
            1: cond = (busy === 1'b1);
            2: cond = (busy === 1'b0);
            3: cond = (ncol === 6'h28);
            default: cond = ((supply_error | reader_check) === 1'b1);
        endcase
    endfunction

    // Bounded poll; a stuck wait ends the run
    task automatic wait_for(input int sel, input int lim);
        for (int n = 0; !cond(sel); n++) begin
            if (n > lim) begin
                mismatches++;
                $display("MISMATCH t=%0t wait %h got=0 exp=1", $time, sel);
                final_report();
            end
            @(posedge clk);
            #1;
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask

    task automatic go_online;
        reg_write(reader_pkg::OFS_CTRL, 16'h0001);
        wait_for(0, 40);
    endtask

    // One card: 40 columns, optional mid-card stop or unstacked card
    task automatic run_card(input logic stop_mid, input logic stack_bad);
        @(posedge clk);
        go <= 1'b1;
        wait_for(1, 20);
        @(posedge clk);
        go <= 1'b0;
        sense_pins.card_in_station <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            sense_zone <= 12'hA50 ^ 12'(i);
            stop_btn   <= stop_mid && i == 20;
            repeat (3) @(posedge clk);
            sense_pins.sense_strobe <= 1'b1;
            repeat (3) @(posedge clk);
            sense_pins.sense_strobe <= 1'b0;
        end
        #1 check(16'({motor_on, online}), stop_mid ? 16'h2 : 16'h3);
        wait_for(3, 400);
        @(posedge clk);
        sense_pins.card_in_station <= 1'b0;
        sense_pins.card_stacked    <= !stack_bad;
        wait_for(2, 120);
        // Ready and motor settle one cycle after busy falls
        @(posedge clk);
        #1 check(16'({motor_on, ready, reader_check}),
            16'({!stop_mid, !(stop_mid || stack_bad), stack_bad}));
        for (int i = 0; i < 40; i++) begin
            check(16'(ctl_model_inst.mem[i]), 16'(12'hA50 ^ 12'(i)));
        end
        @(posedge clk);
        sense_pins.card_stacked <= 1'b0;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        reg_read(reader_pkg::OFS_STATUS, 16'h0000);
        go <= 1'b1;
        repeat (12) @(posedge clk);
        #1 check(16'({busy, ready, irq}), 16'h0);
        go <= 1'b0;
        reg_write(reader_pkg::OFS_IRQ_MASK, 16'h0007);
        go_online();
        reg_read(reader_pkg::OFS_STATUS, 16'h1A00);
        run_card(1'b0, 1'b0);
        reg_read(reader_pkg::OFS_COLUMN, 16'h0A77);
        reg_read(8'h14, 16'h0000);
        reg_write(reader_pkg::OFS_IRQ_MASK, 16'h0000);
        repeat (2) @(posedge clk);
        #1 check(16'(irq), 16'h0);
        reg_write(reader_pkg::OFS_IRQ_MASK, 16'h0007);
        reg_read(reader_pkg::OFS_IRQ_STAT, 16'h0005);
        check(16'(irq), 16'h1);
        reg_write(reader_pkg::OFS_IRQ_STAT, 16'h0005);
        reg_read(reader_pkg::OFS_IRQ_STAT, 16'h0000);
        check(16'(irq), 16'h0);
        run_card(1'b0, 1'b1);
        go_online();
        run_card(1'b1, 1'b0);
        // Errors: empty, full, feed timeout, jam in feed, light/dark
        for (int k = 0; k < 5; k++) begin
            go_online();
            @(posedge clk);
            case (k)
                0: sense_pins.hopper_empty <= 1'b1;
                1: sense_pins.stacker_full <= 1'b1;
                4: {go, sense_pins} <= {1'b1, 8'h32};
                default: go <= 1'b1;
            endcase
            if (k == 3) begin
                wait_for(1, 20);
                @(posedge clk);
                sense_pins.jam_sense <= 1'b1;
            end
            wait_for(4, 120);
            repeat (2) @(posedge clk);
            #1 check(16'({supply_error, reader_check,
                ctl_model_inst.err_seen, online, ready}),
                k < 2 ? 16'h28 : 16'h14);
            go <= 1'b0;
            if (k < 2) begin
                reg_write(reader_pkg::OFS_CTRL, 16'h0001);
                repeat (6) @(posedge clk);
                #1 check(16'({supply_error, online}), 16'h2);
            end
            repeat (2) @(posedge clk);
            // Sensors must clear the synchroniser before the start
            sense_pins <= 8'h20;
            repeat (2) @(posedge clk);
            go_online();
            check(16'({supply_error, reader_check}), 16'h0);
        end
        final_report();
    end
endmodule
